// >>> design/ucr_channel_regs.sv
// Register file and host-bus decode of an eight-channel serial controller
`timescale 1ns/100ps
`include "ucr_consts.svh"
module ucr_channel_regs
	import ucr_pkg::*;
(
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic cs_n,
	input wire logic ior_n,
	input wire logic iow_n,
	input wire logic [6:0] addr,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe,
	input wire ucr_byte_t rx_char [`UCR_CHANNELS],
	input wire ucr_byte_t line_status_in [`UCR_CHANNELS],
	input wire ucr_byte_t modem_status_in [`UCR_CHANNELS],
	input wire logic [3:0] int_source [`UCR_CHANNELS],
	input wire logic [1:0] isr_ext [`UCR_CHANNELS],
	input wire ucr_flags_t flow_event [`UCR_CHANNELS],
	output ucr_byte_t tx_data [`UCR_CHANNELS],
	output logic [7:0] tx_load,
	output logic [7:0] rx_read,
	output logic [7:0] rx_fifo_reset,
	output logic [7:0] tx_fifo_reset,
	output ucr_byte_t divisor_low [`UCR_CHANNELS],
	output ucr_byte_t divisor_high [`UCR_CHANNELS],
	output ucr_byte_t divisor_fraction [`UCR_CHANNELS],
	output ucr_byte_t interrupt_enable [`UCR_CHANNELS],
	output ucr_byte_t fifo_control [`UCR_CHANNELS],
	output ucr_byte_t line_control [`UCR_CHANNELS],
	output ucr_byte_t modem_control [`UCR_CHANNELS],
	output ucr_byte_t half_duplex_ctl [`UCR_CHANNELS],
	output ucr_byte_t feature_control [`UCR_CHANNELS],
	output ucr_byte_t enhanced_function [`UCR_CHANNELS],
	output ucr_byte_t stop_char_one [`UCR_CHANNELS],
	output ucr_byte_t stop_char_two [`UCR_CHANNELS],
	output ucr_byte_t resume_char_one [`UCR_CHANNELS],
	output ucr_byte_t resume_char_two [`UCR_CHANNELS]
);

	////////////////////////////////////////////////////////////////////////
	// Reset and pin synchronisers

	// Reset release chain
	logic [1:0] rst_sync;
	// Synchronised reset, active low
	logic rst_n;
	// First and second pin stages
	logic [17:0] pin_s1;
	logic [17:0] pin_s2;

	assign rst_n = rst_sync[1];

	// Release reset through two flops, assert at once
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			rst_sync <= 2'h0;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end

	// Bus pins are asynchronous to ref_clk; only s2 feeds logic
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_s1 <= 18'h38000;
			pin_s2 <= 18'h38000;
		end
		else
		begin
			pin_s1 <= {cs_n, ior_n, iow_n, addr, data_in};
			pin_s2 <= pin_s1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Strobe edges

	// Synchronised strobes and fields
	logic rd_now;
	logic wr_now;
	logic [2:0] wch;
	logic [3:0] wloc;
	ucr_byte_t wdata;
	// Previous strobe levels
	logic rd_act;
	logic wr_act;
	// One-cycle strobe events
	logic rd_start;
	logic rd_end;
	logic wr_fire;
	// Address held across a read
	logic [2:0] rch;
	logic [3:0] rloc;

	assign rd_now = ~pin_s2[17] & ~pin_s2[16];
	assign wr_now = ~pin_s2[17] & ~pin_s2[15];
	// Upper address lines pick the channel
	assign wch = pin_s2[14:12];
	// low four lines
	// Location inside the channel set
	assign wloc = pin_s2[11:8];
	assign wdata = pin_s2[7:0];
	assign rd_start = rd_now & ~rd_act;
	assign rd_end = ~rd_now & rd_act;
	// Write acts once, at the leading edge of the strobe
	assign wr_fire = wr_now & ~wr_act;

	// Strobe history
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rd_act <= 1'b0;
			wr_act <= 1'b0;
		end
		else
		begin
			rd_act <= rd_now;
			wr_act <= wr_now;
		end
	end

	// Read address held so the trailing-edge effects hit it
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rch <= 3'h0;
			rloc <= 4'h0;
		end
		else if (rd_start)
		begin
			rch <= wch;
			rloc <= wloc;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Per-channel register file

	// Scratch bytes and flow flags
	ucr_byte_t scratch_pad [`UCR_CHANNELS];
	ucr_flags_t flow_flags [`UCR_CHANNELS];

	genvar ch;
	generate
		for (ch = 0; ch < `UCR_CHANNELS; ch++)
		begin : g_chan
			// Write to this channel this cycle
			logic sel;
			logic dlab;
			logic enh;
			logic flag_clr;

			assign sel = wr_fire && (wch == 3'(ch));
			assign dlab = line_control[ch][`UCR_DIV_ACCESS_BIT];
			assign enh = enhanced_function[ch][`UCR_ENH_BIT];
			// clear after read
			// Clear at the end of a flag read
			assign flag_clr = rd_end && (rch == 3'(ch)) &&
				(rloc == `UCR_LOC_STOP1);

			// set wins
			// Events land even in the clearing cycle
			always_ff @(posedge ref_clk or negedge rst_n)
			begin
				if (!rst_n)
					flow_flags[ch] <= 4'h0;
				else
					flow_flags[ch] <= (flag_clr ? 4'h0 : flow_flags[ch])
						| flow_event[ch];
			end

			// Strobe pulses towards the channel datapath
			always_ff @(posedge ref_clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					tx_load[ch] <= 1'b0;
					rx_read[ch] <= 1'b0;
					rx_fifo_reset[ch] <= 1'b0;
					tx_fifo_reset[ch] <= 1'b0;
				end
				else
				begin
					tx_load[ch] <= sel && wloc == `UCR_LOC_DATA && !dlab;
					rx_read[ch] <= rd_end && rch == 3'(ch) &&
						rloc == `UCR_LOC_DATA && !dlab;
					rx_fifo_reset[ch] <= sel && wloc == `UCR_LOC_ISR &&
						!dlab && wdata[1];
					tx_fifo_reset[ch] <= sel && wloc == `UCR_LOC_ISR &&
						!dlab && wdata[2];
				end
			end

			// Configuration bytes
			always_ff @(posedge ref_clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					tx_data[ch] <= `UCR_RST_BYTE;
					divisor_low[ch] <= `UCR_RST_BYTE;
					divisor_high[ch] <= `UCR_RST_BYTE;
					divisor_fraction[ch] <= `UCR_RST_BYTE;
					interrupt_enable[ch] <= `UCR_RST_BYTE;
					fifo_control[ch] <= `UCR_RST_BYTE;
					line_control[ch] <= `UCR_RST_BYTE;
					modem_control[ch] <= `UCR_RST_BYTE;
					half_duplex_ctl[ch] <= `UCR_RST_BYTE;
					scratch_pad[ch] <= `UCR_RST_BYTE;
					feature_control[ch] <= `UCR_RST_BYTE;
					enhanced_function[ch] <= `UCR_RST_BYTE;
					stop_char_one[ch] <= `UCR_RST_BYTE;
					stop_char_two[ch] <= `UCR_RST_BYTE;
					resume_char_one[ch] <= `UCR_RST_BYTE;
					resume_char_two[ch] <= `UCR_RST_BYTE;
				end
				else if (sel)
				begin
					unique case (wloc)
						`UCR_LOC_DATA:
							if (dlab)
								divisor_low[ch] <= wdata;
							else
								tx_data[ch] <= wdata;
						`UCR_LOC_IER:
							if (dlab)
								divisor_high[ch] <= wdata;
							else
								interrupt_enable[ch] <= {enh ? wdata[7:5] : 3'h0,
									1'b0, wdata[3:0]};
						`UCR_LOC_ISR:
							if (dlab)
								divisor_fraction[ch] <= wdata & `UCR_FRAC_MASK;
							else
								fifo_control[ch] <= {wdata[7:6],
									enh ? wdata[5:4] : 2'h0, wdata[3], 2'h0,
									wdata[0]};
						`UCR_LOC_LCR:
							line_control[ch] <= wdata;
						`UCR_LOC_MCR:
							modem_control[ch] <= {enh ? wdata[7:5] : 3'h0,
								wdata[4], enh ? wdata[3:2] : 2'h0, wdata[1:0]};
						`UCR_LOC_MSR:
							half_duplex_ctl[ch] <= enh ?
								{wdata[7:2], 1'b0, wdata[0]} : 8'h00;
						`UCR_LOC_SPR:
							scratch_pad[ch] <= wdata;
						`UCR_LOC_FEATURE_CONTROL:
							feature_control[ch] <= wdata & `UCR_FEATURE_CONTROL_MASK;
						`UCR_LOC_EFR:
							enhanced_function[ch] <= wdata;
						`UCR_LOC_STOP1:
							stop_char_one[ch] <= wdata;
						`UCR_LOC_STOP2:
							stop_char_two[ch] <= wdata;
						`UCR_LOC_RES1:
							resume_char_one[ch] <= wdata;
						`UCR_LOC_RES2:
							resume_char_two[ch] <= wdata;
						`UCR_LOC_LSR, `UCR_LOC_RSV_A, `UCR_LOC_RSV_B:
						begin
						end
					endcase
				end
				else if (!enh)
				begin
					// drop extended fields
					// Stale enhanced settings must not act once disabled
					interrupt_enable[ch][7:5] <= 3'h0;
					fifo_control[ch][5:4] <= 2'h0;
					modem_control[ch][7:5] <= 3'h0;
					modem_control[ch][3:2] <= 2'h0;
					half_duplex_ctl[ch] <= 8'h00;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Read path

	// Value for the addressed location
	ucr_byte_t next_rdata;
	// Bank and enhanced bits of the addressed channel
	logic rdlab;
	logic renh;

	assign rdlab = line_control[wch][`UCR_DIV_ACCESS_BIT];
	assign renh = enhanced_function[wch][`UCR_ENH_BIT];

	// Read multiplexer
	always_comb
	begin
		next_rdata = 8'h00;
		unique case (wloc)
			`UCR_LOC_DATA:
				next_rdata = rdlab ? divisor_low[wch] : rx_char[wch];
			`UCR_LOC_IER:
				next_rdata = rdlab ? divisor_high[wch]
					: interrupt_enable[wch];
			`UCR_LOC_ISR:
				next_rdata = rdlab ? divisor_fraction[wch] :
					{{2{fifo_control[wch][`UCR_FIFO_EN_BIT]}},
					renh ? isr_ext[wch] : 2'h0, int_source[wch]};
			`UCR_LOC_LCR:
				next_rdata = line_control[wch];
			`UCR_LOC_MCR:
				next_rdata = modem_control[wch];
			`UCR_LOC_LSR:
				next_rdata = line_status_in[wch];
			`UCR_LOC_MSR:
				next_rdata = modem_status_in[wch];
			`UCR_LOC_SPR:
				next_rdata = scratch_pad[wch];
			`UCR_LOC_FEATURE_CONTROL:
				next_rdata = feature_control[wch];
			`UCR_LOC_EFR:
				next_rdata = enhanced_function[wch];
			`UCR_LOC_STOP1:
				next_rdata = {4'h0, flow_flags[wch]};
			`UCR_LOC_RSV_A, `UCR_LOC_RSV_B, `UCR_LOC_STOP2,
			`UCR_LOC_RES1, `UCR_LOC_RES2:
				next_rdata = 8'h00;
		endcase
	end

	// Data captured once per read, driven while the strobe lasts
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			data_out <= 8'h00;
			data_oe <= 1'b0;
		end
		else
		begin
			data_oe <= rd_now;
			if (rd_start)
				data_out <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	line_ctl_write_a: assert property (
		wr_fire && wloc == `UCR_LOC_LCR |=>
		line_control[$past(wch)] == $past(wdata))
		else $error("line control not written");
	thr_load_a: assert property (
		wr_fire && wloc == `UCR_LOC_DATA && !rdlab |=>
		tx_load[$past(wch)] && tx_data[$past(wch)] == $past(wdata))
		else $error("transmit load missing");
	div_low_write_a: assert property (
		wr_fire && wloc == `UCR_LOC_DATA && rdlab |=>
		divisor_low[$past(wch)] == $past(wdata) && tx_load == 8'h00)
		else $error("divisor low not written");
	frac_read_a: assert property (
		rd_start && wloc == `UCR_LOC_ISR && rdlab |=>
		data_out[7:4] == 4'h0)
		else $error("fraction upper bits not zero");
	enh_gate_a: assert property (
		!enhanced_function[0][`UCR_ENH_BIT] |=>
		interrupt_enable[0][7:5] == 3'h0 && half_duplex_ctl[0] == 8'h00)
		else $error("extended field live while disabled");
	scratch_read_a: assert property (
		rd_start && wloc == `UCR_LOC_SPR |=>
		data_out == scratch_pad[rch] && data_oe)
		else $error("scratch read mismatch");
	rsvd_read_a: assert property (
		rd_start && (wloc == `UCR_LOC_RSV_A || wloc == `UCR_LOC_RES2)
		|=> data_out == 8'h00)
		else $error("reserved read not zero");
	flag_clear_a: assert property (
		rd_end && rloc == `UCR_LOC_STOP1 && flow_event[rch] == 4'h0
		|=> flow_flags[$past(rch)] == 4'h0)
		else $error("flags not cleared by read");
	flag_set_a: assert property (
		flow_event[0][0] |=> flow_flags[0][0])
		else $error("flow event lost");
	rx_pop_a: assert property (
		rd_end && rloc == `UCR_LOC_DATA && !line_control[rch][7]
		|=> rx_read[$past(rch)] ##1 rx_read == 8'h00)
		else $error("receive pop wrong");
	fifo_reset_a: assert property (
		wr_fire && wloc == `UCR_LOC_ISR && !rdlab && wdata[1] |=>
		rx_fifo_reset[$past(wch)] && fifo_control[$past(wch)][1] == 1'b0)
		else $error("receive fifo reset pulse missing");
	feature_control_mask_a: assert property (
		wr_fire && wloc == `UCR_LOC_FEATURE_CONTROL |=>
		(feature_control[$past(wch)] & 8'hCF) == 8'h00)
		else $error("feature control spare bits set");

	cov_div_write: cover property (wr_fire && wloc == 4'h0 && rdlab);
	cov_flag_read: cover property (rd_end && rloc == `UCR_LOC_STOP1);
	cov_enh_on: cover property (wr_fire && wloc == `UCR_LOC_EFR
		&& wdata[4]);

endmodule

// >>> pkg/ucr_consts.svh
// Offsets, field positions and reset values of the channel register bank
// Operation
// - Eight channels, sixteen bytes each, A3-A0
// - Low eight standard, upper eight enhanced
// - Bank zero: location 0 receive/transmit
// - Bank one: divisor low, high, fraction
// - Location 1 is interrupt enable
// - Location 2 read is interrupt status
// - Location 2 write is FIFO control
// - Location 3 is line control, both banks
// - Location 4 is modem control
// - Location 5 is read-only line status
// - Location 6: modem status, half-duplex control
// - Location 7 is a plain scratch byte
// - Location 9 is enhanced function
// - Extended fields need enhanced bit four
// - Location 12: stop char one, flags
// - Location 13: stop char two
// - Location 14: resume char one
// - Location 15: resume char two
// - Flow flags low nibble, clear on read
`ifndef UCR_CONSTS_SVH
`define UCR_CONSTS_SVH
`define UCR_CHANNELS 8
`define UCR_LOC_DATA 4'h0
`define UCR_LOC_IER 4'h1
`define UCR_LOC_ISR 4'h2
`define UCR_LOC_LCR 4'h3
`define UCR_LOC_MCR 4'h4
`define UCR_LOC_LSR 4'h5
`define UCR_LOC_MSR 4'h6
`define UCR_LOC_SPR 4'h7
`define UCR_LOC_FEATURE_CONTROL 4'h8
`define UCR_LOC_EFR 4'h9
`define UCR_LOC_RSV_A 4'hA
`define UCR_LOC_RSV_B 4'hB
`define UCR_LOC_STOP1 4'hC
`define UCR_LOC_STOP2 4'hD
`define UCR_LOC_RES1 4'hE
`define UCR_LOC_RES2 4'hF
`define UCR_DIV_ACCESS_BIT 7
`define UCR_ENH_BIT 4
`define UCR_FIFO_EN_BIT 0
`define UCR_RST_BYTE 8'h00
`define UCR_FEATURE_CONTROL_MASK 8'h30
`define UCR_FRAC_MASK 8'h0F
`endif

// >>> pkg/ucr_pkg.sv
// Shared types of the channel register bank
package ucr_pkg;
	// One register byte
	typedef logic [7:0] ucr_byte_t;
	// Four flow-character flags of one channel
	typedef logic [3:0] ucr_flags_t;
endpackage

// >>> tb/ucr_host_model.sv
// Host bus model that drives the channel register bank pins
`timescale 1ns/100ps
module ucr_host_model
	import ucr_pkg::*;
(
	input wire logic ref_clk,
	output logic cs_n,
	output logic ior_n,
	output logic iow_n,
	output logic [6:0] addr,
	output logic [7:0] data_in,
	input wire logic [7:0] data_out
);
	// Idle bus: no strobe active
	initial
	begin
		cs_n = 1'b1;
		ior_n = 1'b1;
		iow_n = 1'b1;
		addr = 7'h00;
		data_in = 8'h00;
	end
	////////////////////////////////////////////////////////////////////////
	// One strobe cycle, read or write
	task automatic cyc(input logic is_rd, input logic [6:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(negedge ref_clk);
		addr = a;
		data_in = d;
		cs_n = 1'b0;
		ior_n = !is_rd;
		iow_n = is_rd;
		// Long low time covers the pin sync plus capture
		repeat (6) @(negedge ref_clk);
		q = data_out;
		cs_n = 1'b1;
		ior_n = 1'b1;
		iow_n = 1'b1;
		// Released data pins must not keep the last value
		data_in = ~d;
		// Recovery so the synced strobe rises before the next one
		repeat (6) @(negedge ref_clk);
	endtask
endmodule

// >>> tb/uart_channel_register_decode_tb.sv
// Self-checking bench of the channel register bank
`timescale 1ns/100ps
module uart_channel_register_decode_tb
	import ucr_pkg::*;
;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic cs_n, ior_n, iow_n;
	logic [6:0] addr;
	logic [7:0] data_in, data_out;
	ucr_byte_t rx_char [8], ls_in [8], ms_in [8];
	logic [3:0] int_source [8];
	logic [1:0] isr_ext [8];
	ucr_flags_t flow_event [8];
	ucr_byte_t tx_data [8], div_lo [8], fifo_ctl [8], hd_ctl [8];
	ucr_byte_t stop1 [8], stop2 [8], res1 [8], res2 [8];
	int seed = 75;
	int error_cnt = 0;
	int check_count = 0;
	int cycles = 0;
	logic [7:0] d, e, sp [8];
	logic [3:0] f;
	////////////////////////////////////////////////////////////////////////
	ucr_host_model ucr_host_model_i (.ref_clk(ref_clk), .cs_n(cs_n),
		.ior_n(ior_n), .iow_n(iow_n), .addr(addr), .data_in(data_in),
		.data_out(data_out));
	ucr_channel_regs ucr_channel_regs_i (.ref_clk(ref_clk), .arst_n(arst_n),
		.cs_n(cs_n), .ior_n(ior_n), .iow_n(iow_n), .addr(addr),
		.data_in(data_in), .data_out(data_out), .data_oe(),
		.rx_char(rx_char), .line_status_in(ls_in), .modem_status_in(ms_in),
		.int_source(int_source), .isr_ext(isr_ext), .flow_event(flow_event),
		.tx_data(tx_data), .tx_load(), .rx_read(), .rx_fifo_reset(),
		.tx_fifo_reset(), .divisor_low(div_lo), .divisor_high(),
		.divisor_fraction(), .interrupt_enable(), .fifo_control(fifo_ctl),
		.line_control(), .modem_control(), .half_duplex_ctl(hd_ctl),
		.feature_control(), .enhanced_function(), .stop_char_one(stop1),
		.stop_char_two(stop2), .resume_char_one(res1),
		.resume_char_two(res2));
	////////////////////////////////////////////////////////////////////////
	// 125 MHz clock
	initial
	begin
		forever #4 ref_clk = ~ref_clk;
	end
	// Cycle ceiling: about 6000 cycles expected
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			error_cnt++;
			end_of_test();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input int c, input logic [3:0] loc, input logic [7:0] v);
		logic [7:0] q;
		ucr_host_model_i.cyc(1'b0, {c[2:0], loc}, v, q);
	endtask
	task automatic rdchk(input int c, input logic [3:0] loc,
		input logic [7:0] x);
		logic [7:0] q;
		ucr_host_model_i.cyc(1'b1, {c[2:0], loc}, 8'h00, q);
		check(q, x);
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		// Random live status inputs, fixed for the run
		for (int k = 0; k < 8; k++)
		begin
			rx_char[k] = 8'($random(seed));
			ls_in[k] = 8'($random(seed));
			ms_in[k] = 8'($random(seed));
			int_source[k] = 4'($random(seed));
			isr_ext[k] = 2'($random(seed));
			flow_event[k] = 4'h0;
			sp[k] = 8'($random(seed));
		end
		repeat (8) @(negedge ref_clk);
		arst_n = 1'b1;
		repeat (5) @(negedge ref_clk);
		// Distinct scratch byte per channel, read back at the end
		for (int ch = 0; ch < 8; ch++)
			wr(ch, 4'h7, sp[ch]);
		for (int ch = 0; ch < 8; ch++)
		begin
			d = 8'($random(seed));
			// Divisor bank open
			wr(ch, 4'h3, 8'h80);
			wr(ch, 4'h0, d);
			wr(ch, 4'h1, ~d);
			wr(ch, 4'h2, d);
			rdchk(ch, 4'h0, d);
			rdchk(ch, 4'h1, ~d);
			rdchk(ch, 4'h2, d & 8'h0F);
			rdchk(ch, 4'h3, 8'h80);
			check(div_lo[ch], d);
			// Normal bank: data location
			wr(ch, 4'h3, 8'h03);
			rdchk(ch, 4'h3, 8'h03);
			wr(ch, 4'h0, ~d);
			check(tx_data[ch], ~d);
			rdchk(ch, 4'h0, rx_char[ch]);
			// Extended fields off, then on
			for (int en = 0; en < 2; en++)
			begin
				e = 8'($random(seed));
				e[4] = en[0];
				wr(ch, 4'h9, e);
				rdchk(ch, 4'h9, e);
				wr(ch, 4'h1, 8'hFF);
				rdchk(ch, 4'h1, en ? 8'hEF : 8'h0F);
				wr(ch, 4'h4, 8'hFF);
				rdchk(ch, 4'h4, en ? 8'hFF : 8'h13);
				wr(ch, 4'h2, 8'hFF);
				check(fifo_ctl[ch], en ? 8'hF9 : 8'hC9);
				rdchk(ch, 4'h2, {2'b11, en ? isr_ext[ch] : 2'b00,
					int_source[ch]});
				wr(ch, 4'h6, 8'hFF);
				check(hd_ctl[ch], en ? 8'hFD : 8'h00);
			end
			// Status location ignores writes; feature control keeps only bits 5:4
			wr(ch, 4'h5, ~ls_in[ch]);
			rdchk(ch, 4'h5, ls_in[ch]);
			rdchk(ch, 4'h6, ms_in[ch]);
			wr(ch, 4'h8, 8'hFF);
			rdchk(ch, 4'h8, 8'h30);
			// Flow characters and reserved reads
			wr(ch, 4'hC, d);
			wr(ch, 4'hD, ~d);
			wr(ch, 4'hE, d ^ 8'h5A);
			wr(ch, 4'hF, d ^ 8'hA5);
			check(stop1[ch], d);
			check(stop2[ch], ~d);
			check(res1[ch], d ^ 8'h5A);
			check(res2[ch], d ^ 8'hA5);
			for (int k = 10; k < 16; k++)
			begin
				if (k == 12)
					continue;
				wr(ch, 4'(k), 8'hFF);
				rdchk(ch, 4'(k), 8'h00);
			end
			// Flag pulse, then clear on read
			f = 4'($random(seed)) | 4'h1;
			@(negedge ref_clk);
			flow_event[ch] = f;
			@(negedge ref_clk);
			flow_event[ch] = 4'h0;
			rdchk(ch, 4'hC, {4'h0, f});
			rdchk(ch, 4'hC, 8'h00);
		end
		for (int ch = 0; ch < 8; ch++)
			rdchk(ch, 4'h7, sp[ch]);
		end_of_test();
	end
endmodule
